// >>> rtl/scd_pkg.sv
// shared constants and carriers of the servo command decoder
// assumes: one core clock; serial link pins sampled by that clock

package scd_pkg;

  // ****************************************
  // command layout
  // ****************************************
  localparam int CMD_W = 8;
  localparam int NIB_W = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] GRP_FOCUS = 4'h0;
  localparam logic [3:0] GRP_TRACK = 4'h1;
  localparam logic [3:0] GRP_MODE = 4'h2;
  localparam logic [3:0] GRP_PEAK = 4'h3;
  localparam logic [3:0] GRP_HIZ_LAST = 4'h7;
  localparam logic [3:0] LATCH_RST = 4'h0;
  localparam logic [3:0] SENSE_RST = 4'h0;
  // link pins at rest {control, clock, data, latch}: control and latch idle high
  localparam logic [3:0] LINK_IDLE = 4'h9;

  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int MODE_TRK_LSB = 2;
  localparam int MODE_SLED_LSB = 0;
  localparam int GAIN_SHOCK_BIT = 3;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_FWD = 2'h2;
  localparam logic [1:0] MODE_REV = 2'h3;
  localparam logic [3:0] MODE_RESUME = 4'h5;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] group;
    logic [3:0] data;
  } scd_cmd_t;

  typedef struct packed {
    logic rev_feed_switch;
    logic fwd_feed_switch;
    logic rev_jump_switch;
    logic fwd_jump_switch;
    logic sled_on_switch;
    logic tracking_on_switch;
  } scd_tm_t;

  typedef struct packed {
    logic focus_loop_switch;
    logic focus_switch_c;
    logic focus_switch_b;
    logic focus_switch_a;
  } scd_focus_t;

  typedef struct packed {
    logic anti_shock_en;
    logic brake_en;
    logic track_gain_sw_b;
    logic track_gain_sw_a;
  } scd_gain_t;

  typedef struct packed {
    logic search_peak_bit1;
    logic search_peak_bit0;
    logic sled_peak_bit1;
    logic sled_peak_bit0;
  } scd_peak_t;

  typedef struct packed {
    logic inner_limit_stop;
    logic track_zero_cross;
    logic anti_shock_flag;
    logic focus_zero_cross;
  } scd_stat_t;

  // mode nibble to the six servo switches; swap inverts the jump pulse
  function automatic scd_tm_t scd_tm_sw(input logic [3:0] mode, input logic swap);
    scd_tm_t t;
    logic [1:0] trk;
    logic [1:0] sled;
    t = '0;
    trk = mode[MODE_TRK_LSB +: 2];
    sled = mode[MODE_SLED_LSB +: 2];
    t.tracking_on_switch = (trk == MODE_ON);
    t.fwd_jump_switch = swap ? (trk == MODE_REV) : (trk == MODE_FWD);
    t.rev_jump_switch = swap ? (trk == MODE_FWD) : (trk == MODE_REV);
    t.sled_on_switch = (sled == MODE_ON);
    t.fwd_feed_switch = (sled == MODE_FWD);
    t.rev_feed_switch = (sled == MODE_REV);
    return t;
  endfunction

endpackage

// >>> rtl/scd_sync.sv
// two-stage synchroniser for levels arriving from outside the core clock
// assumes: inputs are slow against the core clock
`timescale 1ns/1ps

module scd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // ****************************************
  // two flops, first read only by second
  // ****************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // rest level of the pins, so release shows no false edge
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// >>> rtl/scd_shift.sv
// serial command receiver: shifts on link clock rises, emits on latch fall
// assumes: all three link inputs already synchronised to core_clk_i
`timescale 1ns/1ps

module scd_shift
  import scd_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // synchronised link
  input wire logic link_clk_s_i,
  input wire logic link_data_s_i,
  input wire logic latch_n_s_i,
  // assembled command
  output scd_pkg::scd_cmd_t cmd_o,
  output logic cmd_valid_o
);

  logic [CMD_W-1:0] shift_q;
  logic clk_prev_q;
  logic latch_prev_q;

  // ****************************************
  // edge history
  // ****************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_prev_q <= 1'b0;
      latch_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= link_clk_s_i;
      latch_prev_q <= latch_n_s_i;
    end
  end

  // ****************************************
  // shifting and latching
  // ****************************************
  // msb first shift
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_q <= '0;
    end else if (link_clk_s_i && !clk_prev_q) begin
      shift_q <= {shift_q[CMD_W-2:0], link_data_s_i};
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_o <= '0;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= !latch_n_s_i && latch_prev_q;
      if (!latch_n_s_i && latch_prev_q) begin
        cmd_o <= shift_q;
      end
    end
  end

  AST_ONE_PULSE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cmd_valid_o |=> !cmd_valid_o)
    else $error("command strobe longer than one cycle");

endmodule

// >>> rtl/scd_top.sv
// servo command decoder: serial commands to servo switch states
// assumes: host link pins and status comparators are asynchronous
`timescale 1ns/1ps

module scd_top
  import scd_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // serial link from host
  input wire logic link_clk_i,
  input wire logic link_data_i,
  input wire logic command_latch_n_i,
  input wire logic direct_jump_control_i,
  // status from analog comparators
  input wire scd_pkg::scd_stat_t status_i,
  // sense pin
  output logic sense_output_o,
  output logic sense_output_oe_o,
  // servo switches
  output scd_pkg::scd_focus_t focus_sw_o,
  output scd_pkg::scd_gain_t gain_sw_o,
  output scd_pkg::scd_tm_t tm_sw_o,
  output scd_pkg::scd_peak_t peak_o
);

  // ****************************************
  // declarations
  // ****************************************
  typedef enum logic [1:0] {
    JA_IDLE = 2'b00,
    JA_DECEL = 2'b01,
    JA_RESUME = 2'b11
  } scd_jump_t;

  scd_jump_t jump_q;
  scd_jump_t jump_d;
  logic [2:0] link_s;
  logic jump_ctl_s;
  scd_stat_t stat_s;
  scd_cmd_t cmd;
  logic cmd_valid;
  logic mode_hit;
  logic resume_hit;
  logic [3:0] focus_q;
  logic [3:0] gain_q;
  logic [3:0] mode_q;
  logic [3:0] peak_q;
  logic [3:0] sense_sel_q;

  // ****************************************
  // synchronisers and receiver
  // ****************************************
  // link clock is sampled, never used as a clock
  // rest-level reset: a zero here would fake a latch fall and a resume
  scd_sync #(.W(4), .RST_VAL(LINK_IDLE)) u_link_sync (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({direct_jump_control_i, link_clk_i, link_data_i, command_latch_n_i}),
    .sync_o({jump_ctl_s, link_s})
  );

  scd_sync #(.W(4)) u_stat_sync (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(status_i),
    .sync_o(stat_s)
  );

  scd_shift u_shift (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .link_clk_s_i(link_s[2]),
    .link_data_s_i(link_s[1]),
    .latch_n_s_i(link_s[0]),
    .cmd_o(cmd),
    .cmd_valid_o(cmd_valid)
  );

  assign mode_hit = cmd_valid && (cmd.group == GRP_MODE);

  // ****************************************
  // command latches
  // ****************************************
  // focus group
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      focus_q <= LATCH_RST;
    end else if (cmd_valid && cmd.group == GRP_FOCUS) begin
      focus_q <= cmd.data;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_q <= LATCH_RST;
    end else if (cmd_valid && cmd.group == GRP_TRACK) begin
      gain_q <= cmd.data;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      peak_q <= LATCH_RST;
    end else if (cmd_valid && cmd.group == GRP_PEAK) begin
      peak_q <= cmd.data;
    end
  end

  // mode latch, resume writes both servos on
  // a command landing in the resume cycle wins: it is the newer intent
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= LATCH_RST;
    end else if (mode_hit) begin
      mode_q <= cmd.data;
    end else if (resume_hit) begin
      mode_q <= MODE_RESUME;
    end
  end

  // last group steers the sense pin
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sense_sel_q <= SENSE_RST;
    end else if (cmd_valid) begin
      sense_sel_q <= cmd.group;
    end
  end

  // ****************************************
  // jump assist sequencer
  // ****************************************
  // host holds direct control high until decel
  always_comb begin
    jump_d = jump_q;
    case (jump_q)
      JA_IDLE: begin
        if (!jump_ctl_s) begin
          jump_d = JA_DECEL;
        end
      end
      JA_DECEL: begin
        if (jump_ctl_s) begin
          jump_d = JA_RESUME;
        end
      end
      JA_RESUME: begin
        jump_d = jump_ctl_s ? JA_IDLE : JA_DECEL;
      end
      default: begin
        jump_d = JA_IDLE;
      end
    endcase
  end

  // rising direct control ends the decel
  assign resume_hit = (jump_q == JA_DECEL) && jump_ctl_s;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      jump_q <= JA_IDLE;
    end else begin
      jump_q <= jump_d;
    end
  end

  // ****************************************
  // switch outputs
  // ****************************************
  // mode decode, swapped while low
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tm_sw_o <= '0;
    end else begin
      tm_sw_o <= scd_tm_sw(mode_q, !jump_ctl_s);
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_sw_o <= '0;
    end else begin
      gain_sw_o <= gain_q ^ {2'h0, {2{gain_q[GAIN_SHOCK_BIT] && stat_s.anti_shock_flag}}};
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      focus_sw_o <= '0;
      peak_o <= '0;
    end else begin
      focus_sw_o <= focus_q;
      peak_o <= peak_q;
    end
  end

  // sense mux; groups past three release the pin
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sense_output_o <= 1'b0;
      sense_output_oe_o <= 1'b1;
    end else begin
      sense_output_oe_o <= (sense_sel_q <= GRP_PEAK);
      case (sense_sel_q)
        GRP_FOCUS: begin
          sense_output_o <= stat_s.focus_zero_cross;
        end
        GRP_TRACK: begin
          sense_output_o <= stat_s.anti_shock_flag;
        end
        GRP_MODE: begin
          sense_output_o <= stat_s.track_zero_cross;
        end
        GRP_PEAK: begin
          sense_output_o <= stat_s.inner_limit_stop;
        end
        default: begin
          sense_output_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_LATCH_ONLY: assert property (
    !cmd_valid |=> $stable(focus_q) && $stable(gain_q) && $stable(peak_q))
    else $error("latch changed without a command");

  AST_FOCUS_OUT: assert property (
    cmd_valid && cmd.group == GRP_FOCUS |-> ##2 focus_sw_o == $past(cmd.data, 2))
    else $error("focus switches do not follow command");

  AST_SENSE_HIZ: assert property (
    sense_sel_q > GRP_PEAK |=> !sense_output_oe_o)
    else $error("sense pin driven for a release group");

  AST_SENSE_TZC: assert property (
    mode_hit |-> ##2 sense_output_oe_o && sense_output_o == $past(stat_s.track_zero_cross))
    else $error("sense does not show track cross");

  AST_FWD_JUMP: assert property (
    (mode_q[3:2] == MODE_FWD && jump_ctl_s) [*2] |=>
      tm_sw_o.fwd_jump_switch && !tm_sw_o.rev_jump_switch)
    else $error("forward jump not decoded");

  AST_SLED_FEED: assert property (
    mode_q[1:0] == MODE_REV && $stable(mode_q) |=>
      tm_sw_o.rev_feed_switch && !tm_sw_o.sled_on_switch)
    else $error("reverse feed not decoded");

  AST_TRK_ON: assert property (
    mode_q == MODE_RESUME |=> tm_sw_o.tracking_on_switch && tm_sw_o.sled_on_switch)
    else $error("servo on switches missing");

  AST_SWAP: assert property (
    mode_q[3:2] == MODE_REV && !jump_ctl_s |=>
      tm_sw_o.fwd_jump_switch && !tm_sw_o.rev_jump_switch)
    else $error("jump not inverted while direct control low");

  AST_RESUME: assert property (
    resume_hit && !mode_hit |=> mode_q == MODE_RESUME ##1 tm_sw_o.tracking_on_switch)
    else $error("servos not resumed after decel");

  AST_ANTI_SHOCK: assert property (
    gain_q[GAIN_SHOCK_BIT] && stat_s.anti_shock_flag |=>
      gain_sw_o[1:0] == ~$past(gain_q[1:0]))
    else $error("gain switches not inverted");

  AST_GAIN_PLAIN: assert property (
    !gain_q[GAIN_SHOCK_BIT] |=> gain_sw_o == $past(gain_q))
    else $error("gain switches differ from command");

  AST_PEAK: assert property (
    cmd_valid && cmd.group == GRP_PEAK |-> ##2 peak_o == $past(cmd.data, 2))
    else $error("peak bits do not follow command");

  COV_FOCUS_ON: cover property (focus_sw_o.focus_loop_switch);
  COV_JUMP: cover property (jump_q == JA_DECEL ##[1:1000] jump_q == JA_RESUME);
  COV_ANTI: cover property (gain_q[GAIN_SHOCK_BIT] && stat_s.anti_shock_flag);
  COV_HIZ: cover property (!sense_output_oe_o);

endmodule

// >>> bench/scd_host.sv
// host model: drives the three-wire command link and direct jump control
// assumes: core clock given for pacing; link clock 64 ns period, idle low
`timescale 1ns/1ps

module scd_host (
  // pacing clock
  input wire logic core_clk_i,
  // link to device
  output logic link_clk_o,
  output logic link_data_o,
  output logic command_latch_n_o,
  output logic direct_jump_control_o
);
  // ****************************************
  // idle levels
  // ****************************************
  // control idles high
  initial begin
    link_clk_o = 1'b0;
    link_data_o = 1'b0;
    command_latch_n_o = 1'b1;
    direct_jump_control_o = 1'b1;
  end

  // half link period, changes land off the core sampling edge
  task automatic half();
    repeat (4) @(negedge core_clk_i);
  endtask

  // ****************************************
  // serial transfer
  // ****************************************
  // eight bits msb first
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      link_data_o = b[i];
      half();
      link_clk_o = 1'b1;
      half();
      link_clk_o = 1'b0;
    end
    half();
    command_latch_n_o = 1'b0;
    half();
    command_latch_n_o = 1'b1;
    // released line must not look like held data
    link_data_o = ~b[0];
  endtask

  task automatic jump_ctl(input logic v);
    direct_jump_control_o = v;
  endtask
endmodule

// >>> bench/tb.sv
// self-checking bench of the servo command decoder
// assumes: host model drives the link; status levels driven here
`timescale 1ns/1ps

module tb;
  import scd_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  wire link_clk, link_data, latch_n, jump_ctl;
  logic [19:0] obs;
  scd_stat_t stat = '0;
  logic sense, sense_oe;
  scd_focus_t focus;
  scd_gain_t gain;
  scd_tm_t tm;
  scd_peak_t peak;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 5598;
  logic [19:0] exp_q[$];
  logic [3:0] mf = '0, mg = '0, mm = '0, mp = '0, mgrp = '0;
  event obs_ev;

  always #4 core_clk = ~core_clk;

  scd_host i_host (
    .core_clk_i(core_clk),
    .link_clk_o(link_clk),
    .link_data_o(link_data),
    .command_latch_n_o(latch_n),
    .direct_jump_control_o(jump_ctl)
  );

  scd_top i_dut (
    .core_clk_i(core_clk),
    .reset_n_i(reset_n),
    .link_clk_i(link_clk),
    .link_data_i(link_data),
    .command_latch_n_i(latch_n),
    .direct_jump_control_i(jump_ctl),
    .status_i(stat),
    .sense_output_o(sense),
    .sense_output_oe_o(sense_oe),
    .focus_sw_o(focus),
    .gain_sw_o(gain),
    .tm_sw_o(tm),
    .peak_o(peak)
  );

  // ****************************************
  // reference model and comparison
  // ****************************************
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [19:0] predict();
    logic [1:0] t, s;
    logic sw, src, oe;
    t = mm[3:2];
    s = mm[1:0];
    sw = (jump_ctl == 1'b0);
    oe = (mgrp[3:2] == 2'b00);
    case (mgrp[1:0])
      2'h0: src = stat.focus_zero_cross;
      2'h1: src = stat.anti_shock_flag;
      2'h2: src = stat.track_zero_cross;
      default: src = stat.inner_limit_stop;
    endcase
    return {mf, mg[3:2], mg[1:0] ^ {2{mg[3] & stat.anti_shock_flag}},
      s == 2'h3, s == 2'h2, sw ? t == 2'h2 : t == 2'h3, sw ? t == 2'h3 : t == 2'h2,
      s == 2'h1, t == 2'h1, mp, oe, oe & src};
  endfunction

  // outputs settle well inside ten cycles of any stimulus
  task automatic settle();
    repeat (10) @(negedge core_clk);
    exp_q.push_back(predict());
    -> obs_ev;
  endtask

  task automatic cmd(input logic [7:0] b);
    i_host.send(b);
    case (b[7:4])
      4'h0: mf = b[3:0];
      4'h1: mg = b[3:0];
      4'h2: mm = b[3:0];
      4'h3: mp = b[3:0];
      default: ;
    endcase
    mgrp = b[7:4];
    settle();
  endtask

  always @(obs_ev) begin
    obs = {focus, gain, tm, peak, sense_oe, sense & sense_oe};
    check("outputs", obs, exp_q.pop_front());
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    // about 9k cycles of traffic; allow roughly three and a half times that
    #250000;
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (20) @(negedge core_clk);
    stat = 4'h1;
    reset_n = 1'b1;
    settle();
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      cmd(8'h20 + i[7:0]);
    end
    $display("test modes done");
    for (int i = 0; i < 16; i++) begin
      stat = 4'($random(seed));
      cmd(8'h10 + i[7:0]);
    end
    $display("test gain done");
    for (int i = 0; i < 16; i++) begin
      cmd(i[7:0]);
      cmd(8'h30 + i[7:0]);
    end
    $display("test focus peak done");
    for (int i = 0; i < 40; i++) begin
      stat = 4'($random(seed));
      cmd(8'($random(seed)));
    end
    $display("test random done");
    // reset in mid-run clears every latch
    reset_n = 1'b0;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    {mf, mg, mm, mp, mgrp} = '0;
    settle();
    $display("test mid-run reset done");
    // assisted one-track jump, decel on a sensed zero cross
    for (int i = 0; i < 2; i++) begin
      cmd(i == 0 ? 8'h2C : 8'h28);
      stat.track_zero_cross = ~stat.track_zero_cross;
      @(sense);
      @(negedge core_clk);
      i_host.jump_ctl(1'b0);
      settle();
      i_host.jump_ctl(1'b1);
      mm = MODE_RESUME;
      settle();
    end
    $display("test jump done");
    repeat (4) @(negedge core_clk);
    wrap_up();
  end
endmodule
